// File: hw/cpr_router.v
// Camera output port router with trigger manager front end and AXI4-Lite
// What this block does
// - Each output port shows a software level or a chosen internal signal.
// - Each port has its own polarity reverse bit flipping its output.
// - Polarity reverse acts the same for every selected source.
// - Polarity reverse never touches the decoding of input signals.
// - A written software level is held on the port until rewritten.
// - Software level passes the reverse stage before reaching the pin.
// - Exposure source is high during each exposure phase, low otherwise.
// - Strobe rises and falls at two programmable 1 us step delays.
// - Strobe and exposure both start from the frame event, own delays.
// - Each trigger event gives a 5 us pulse source.
// - Trigger events may come from input ports, encoder or multiplier.
// - Each of three trigger modules has its own ready level.
// - Ready idles high, drops on its event, rises when accepting again.
// - Events reaching a module whose ready is low are discarded.
// - A port may select an extra signal by index when enabled.
// - Port 0 as input has programmable debounce and termination switch.
// - Port 0 as output drives its selected, software written level.
// - Any input port can feed any of the three trigger events.
// - Port 0 resets to input with termination off.
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`include "cpr_regs.vh"
module cpr_router (
    input wire sys_clk_i,
    input wire arst_n_i,
    input wire [5:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output wire s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output wire s_axi_wready_o,
    output reg [1:0] s_axi_bresp_o,
    output reg s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [5:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output wire s_axi_arready_o,
    output reg [31:0] s_axi_rdata_o,
    output reg [1:0] s_axi_rresp_o,
    output reg s_axi_rvalid_o,
    input wire s_axi_rready_i,
    input wire p0_i,
    output wire p0_o,
    output wire p0_oe_o,
    output wire p0_term_en_o,
    input wire [1:0] in_i,
    output wire [2:0] out_o,
    input wire enc_tick_i,
    input wire pll_tick_i,
    input wire [2:0] trig_done_i,
    input wire [15:0] extra_sig_i,
    output reg [2:0] trig_event_o
);
    // ======================================================================
    // Functions
    function [31:0] merge_bytes;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] strb;
        integer b;
        begin
            merge_bytes = old_v;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b]) begin
                    merge_bytes[8*b +: 8] = new_v[8*b +: 8];
                end
            end
        end
    endfunction

    function reg_hit;
        input [5:0] addr;
        begin
            reg_hit = ({addr[5:2], 2'b00} <= `CPR_OFS_STATUS);
        end
    endfunction

    function trig_level;
        input [2:0] sel;
        input [2:0] filt;
        input enc;
        input pll;
        begin
            case (sel)
                `CPR_TSRC_IN0: trig_level = filt[0];
                `CPR_TSRC_IN1: trig_level = filt[1];
                `CPR_TSRC_IN2: trig_level = filt[2];
                `CPR_TSRC_ENC: trig_level = enc;
                `CPR_TSRC_PLL: trig_level = pll;
                default: trig_level = 1'b0;
            endcase
        end
    endfunction

    // ======================================================================
    // Declarations
    reg [`CPR_PC_W-1:0] port_cfg_ff [0:3];
    reg [1:0] p0_ctrl_ff;
    reg [15:0] deb_ff;
    reg [11:0] trig_src_ff;
    reg [15:0] stb_rise_ff;
    reg [15:0] stb_fall_ff;
    reg [15:0] exp_rise_ff;
    reg [15:0] exp_fall_ff;
    reg aw_got_ff;
    reg [5:0] aw_addr_ff;
    reg w_got_ff;
    reg [31:0] w_data_ff;
    reg [3:0] w_strb_ff;
    reg [7:0] tick_cnt_ff;
    reg tick_ff;
    reg [3:0] out_ff;
    reg [2:0] filt_ff;
    reg [2:0] rdy_ff;
    reg [2:0] prev_ff;
    wire do_wr;
    wire do_rd;
    wire [5:0] wr_ofs;
    wire [5:0] rd_ofs;
    wire [31:0] wr_val;
    wire [2:0] in_raw;
    wire [2:0] trig_lvl;
    wire [2:0] accepted;
    wire [2:0] trig_pulse;
    wire strobe;
    wire exposure;
    wire [15:0] src_vec;
    integer k;

    // ======================================================================
    // AXI4-Lite handshakes
    assign s_axi_awready_o = ~aw_got_ff & ~s_axi_bvalid_o;
    assign s_axi_wready_o = ~w_got_ff & ~s_axi_bvalid_o;
    assign s_axi_arready_o = ~s_axi_rvalid_o;
    assign do_wr = aw_got_ff & w_got_ff & ~s_axi_bvalid_o;
    assign do_rd = s_axi_arvalid_i & ~s_axi_rvalid_o;
    assign wr_ofs = {aw_addr_ff[5:2], 2'b00};
    assign rd_ofs = {s_axi_araddr_i[5:2], 2'b00};
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_got_ff <= 1'b0;
            aw_addr_ff <= 6'h00;
            w_got_ff <= 1'b0;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `CPR_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_got_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_got_ff <= 1'b1;
                w_data_ff <= s_axi_wdata_i;
                w_strb_ff <= s_axi_wstrb_i;
            end
            if (do_wr) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= (reg_hit(aw_addr_ff) &&
                    wr_ofs != `CPR_OFS_STATUS) ?
                    `CPR_RESP_OKAY : `CPR_RESP_SLVERR;
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Configuration registers
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (k = 0; k < 4; k = k + 1) begin
                port_cfg_ff[k] <= `CPR_PORT_RST;
            end
            p0_ctrl_ff <= `CPR_P0_CTRL_RST;
            deb_ff <= `CPR_DEB_RST;
            trig_src_ff <= {1'b0, `CPR_TRIG_SRC_RST, 1'b0, `CPR_TRIG_SRC_RST,
                1'b0, `CPR_TRIG_SRC_RST};
            stb_rise_ff <= `CPR_DLY_RST;
            stb_fall_ff <= `CPR_DLY_RST;
            exp_rise_ff <= `CPR_DLY_RST;
            exp_fall_ff <= `CPR_DLY_RST;
        end else if (do_wr) begin
            case (wr_ofs)
                `CPR_OFS_PORT0, `CPR_OFS_PORT1, `CPR_OFS_PORT2,
                `CPR_OFS_PORT3: begin
                    port_cfg_ff[wr_ofs[3:2]] <= wr_val[`CPR_PC_W-1:0];
                end
                `CPR_OFS_P0_CTRL: p0_ctrl_ff <= wr_val[1:0];
                `CPR_OFS_DEBOUNCE: deb_ff <= wr_val[15:0];
                `CPR_OFS_TRIG_SRC: trig_src_ff <= wr_val[11:0];
                `CPR_OFS_STB_RISE: stb_rise_ff <= wr_val[15:0];
                `CPR_OFS_STB_FALL: stb_fall_ff <= wr_val[15:0];
                `CPR_OFS_EXP_RISE: exp_rise_ff <= wr_val[15:0];
                `CPR_OFS_EXP_FALL: exp_fall_ff <= wr_val[15:0];
                default: ;
            endcase
        end
    end

    assign wr_val = merge_bytes(nxt_rdata_w(wr_ofs), w_data_ff, w_strb_ff);
    // ======================================================================
    // Register readback
    function [31:0] nxt_rdata_w;
        input [5:0] ofs;
        begin
            case (ofs)
                `CPR_OFS_PORT0: nxt_rdata_w = {19'h0, port_cfg_ff[0]};
                `CPR_OFS_PORT1: nxt_rdata_w = {19'h0, port_cfg_ff[1]};
                `CPR_OFS_PORT2: nxt_rdata_w = {19'h0, port_cfg_ff[2]};
                `CPR_OFS_PORT3: nxt_rdata_w = {19'h0, port_cfg_ff[3]};
                `CPR_OFS_P0_CTRL: nxt_rdata_w = {30'h0, p0_ctrl_ff};
                `CPR_OFS_DEBOUNCE: nxt_rdata_w = {16'h0, deb_ff};
                `CPR_OFS_TRIG_SRC: nxt_rdata_w = {20'h0, trig_src_ff};
                `CPR_OFS_STB_RISE: nxt_rdata_w = {16'h0, stb_rise_ff};
                `CPR_OFS_STB_FALL: nxt_rdata_w = {16'h0, stb_fall_ff};
                `CPR_OFS_EXP_RISE: nxt_rdata_w = {16'h0, exp_rise_ff};
                `CPR_OFS_EXP_FALL: nxt_rdata_w = {16'h0, exp_fall_ff};
                `CPR_OFS_STATUS: nxt_rdata_w = {20'h0, out_ff, 1'b0, filt_ff,
                    1'b0, rdy_ff};
                default: nxt_rdata_w = 32'h00000000;
            endcase
        end
    endfunction

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= `CPR_RESP_OKAY;
        end else if (do_rd) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= nxt_rdata_w(rd_ofs);
            s_axi_rresp_o <= reg_hit(s_axi_araddr_i) ?
                `CPR_RESP_OKAY : `CPR_RESP_SLVERR;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // ======================================================================
    // 1 us tick divider
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tick_cnt_ff <= 8'h00;
            tick_ff <= 1'b0;
        end else if (tick_cnt_ff == `CPR_TICK_LAST) begin
            tick_cnt_ff <= 8'h00;
            tick_ff <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 8'h01;
            tick_ff <= 1'b0;
        end
    end

    // ======================================================================
    // Input debounce, uninverted
    assign in_raw = {in_i, p0_i & ~p0_ctrl_ff[`CPR_P0_DIR_BIT]};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_deb
            reg [15:0] deb_cnt_ff;
            always @(posedge sys_clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    deb_cnt_ff <= 16'h0000;
                    filt_ff[gi] <= 1'b0;
                end else if (in_raw[gi] == filt_ff[gi]) begin
                    deb_cnt_ff <= 16'h0000;
                end else if (deb_cnt_ff >= deb_ff) begin
                    filt_ff[gi] <= in_raw[gi];
                    deb_cnt_ff <= 16'h0000;
                end else if (tick_ff) begin
                    deb_cnt_ff <= deb_cnt_ff + 16'h0001;
                end
            end
        end
    endgenerate

    // ======================================================================
    // Trigger event front end with ready levels
    assign trig_lvl[0] = trig_level(trig_src_ff[`CPR_TS_ACQ_LSB +: 3],
        filt_ff, enc_tick_i, pll_tick_i);
    assign trig_lvl[1] = trig_level(trig_src_ff[`CPR_TS_FRM_LSB +: 3],
        filt_ff, enc_tick_i, pll_tick_i);
    assign trig_lvl[2] = trig_level(trig_src_ff[`CPR_TS_EOE_LSB +: 3],
        filt_ff, enc_tick_i, pll_tick_i);
    assign accepted = trig_lvl & ~prev_ff & rdy_ff;
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev_ff <= 3'h0;
            rdy_ff <= 3'h7;
            trig_event_o <= 3'h0;
        end else begin
            prev_ff <= trig_lvl;
            trig_event_o <= accepted;
            rdy_ff <= (rdy_ff | trig_done_i) & ~accepted;
        end
    end

    // ======================================================================
    // Pulse sources
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_tp
            cpr_us_pulse u_trig_pulse (
                .sys_clk_i(sys_clk_i),
                .arst_n_i(arst_n_i),
                .tick_i(tick_ff),
                .start_i(accepted[gi]),
                .rise_i(16'h0000),
                .fall_i(`CPR_TRIG_PULSE_US),
                .pulse_o(trig_pulse[gi])
            );
        end
    endgenerate

    cpr_us_pulse u_strobe (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .tick_i(tick_ff),
        .start_i(accepted[1]),
        .rise_i(stb_rise_ff),
        .fall_i(stb_fall_ff),
        .pulse_o(strobe)
    );

    cpr_us_pulse u_exposure (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .tick_i(tick_ff),
        .start_i(accepted[1]),
        .rise_i(exp_rise_ff),
        .fall_i(exp_fall_ff),
        .pulse_o(exposure)
    );

    // ======================================================================
    // Output selection and polarity
    assign src_vec = {7'h00, rdy_ff, trig_pulse, strobe, exposure, 1'b0};
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_out
            wire [`CPR_PC_W-1:0] cfg;
            wire lvl;
            assign cfg = port_cfg_ff[gi];
            assign lvl = cfg[`CPR_PC_XON_BIT] ?
                extra_sig_i[cfg[`CPR_PC_XIDX_MSB:`CPR_PC_XIDX_LSB]] :
                (cfg[`CPR_PC_SRC_MSB:`CPR_PC_SRC_LSB] == `CPR_SRC_SW) ?
                cfg[`CPR_PC_SW_BIT] :
                src_vec[cfg[`CPR_PC_SRC_MSB:`CPR_PC_SRC_LSB]];
            always @(posedge sys_clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    out_ff[gi] <= 1'b0;
                end else begin
                    out_ff[gi] <= lvl ^ cfg[`CPR_PC_INV_BIT];
                end
            end
        end
    endgenerate
    assign p0_o = out_ff[0];
    assign p0_oe_o = p0_ctrl_ff[`CPR_P0_DIR_BIT];
    assign p0_term_en_o = p0_ctrl_ff[`CPR_P0_TERM_BIT];
    assign out_o = out_ff[3:1];
endmodule // cpr_router

// File: hw/cpr_regs.vh
// Register map, field positions, reset values and timing of the port router
`ifndef CPR_REGS_VH
`define CPR_REGS_VH
// ==========================================================================
// Register byte offsets
`define CPR_OFS_PORT0      6'h00
`define CPR_OFS_PORT1      6'h04
`define CPR_OFS_PORT2      6'h08
`define CPR_OFS_PORT3      6'h0C
`define CPR_OFS_P0_CTRL    6'h10
`define CPR_OFS_DEBOUNCE   6'h14
`define CPR_OFS_TRIG_SRC   6'h18
`define CPR_OFS_STB_RISE   6'h1C
`define CPR_OFS_STB_FALL   6'h20
`define CPR_OFS_EXP_RISE   6'h24
`define CPR_OFS_EXP_FALL   6'h28
`define CPR_OFS_STATUS     6'h2C
// ==========================================================================
// Port configuration fields
`define CPR_PC_SRC_LSB     0
`define CPR_PC_SRC_MSB     3
`define CPR_PC_INV_BIT     4
`define CPR_PC_SW_BIT      5
`define CPR_PC_XIDX_LSB    8
`define CPR_PC_XIDX_MSB    11
`define CPR_PC_XON_BIT     12
`define CPR_PC_W           13
// Bidirectional port control fields
`define CPR_P0_DIR_BIT     0
`define CPR_P0_TERM_BIT    1
// Trigger source fields, three bits each
`define CPR_TS_ACQ_LSB     0
`define CPR_TS_FRM_LSB     4
`define CPR_TS_EOE_LSB     8
// Status fields
`define CPR_ST_RDY_LSB     0
`define CPR_ST_IN_LSB      4
`define CPR_ST_OUT_LSB     8
// ==========================================================================
// Output source codes
`define CPR_SRC_SW         4'h0
`define CPR_SRC_EXPOSURE   4'h1
`define CPR_SRC_STROBE     4'h2
`define CPR_SRC_ACQ_PULSE  4'h3
`define CPR_SRC_FRM_PULSE  4'h4
`define CPR_SRC_EOE_PULSE  4'h5
`define CPR_SRC_ACQ_RDY    4'h6
`define CPR_SRC_FRM_RDY    4'h7
`define CPR_SRC_EOE_RDY    4'h8
// Trigger source codes
`define CPR_TSRC_IN0       3'h0
`define CPR_TSRC_IN1       3'h1
`define CPR_TSRC_IN2       3'h2
`define CPR_TSRC_ENC       3'h3
`define CPR_TSRC_PLL       3'h4
`define CPR_TSRC_NONE      3'h7
// ==========================================================================
// Reset values
`define CPR_PORT_RST       13'h0000
`define CPR_P0_CTRL_RST    2'h0
`define CPR_DEB_RST        16'h0000
`define CPR_TRIG_SRC_RST   3'h7
`define CPR_DLY_RST        16'h0000
// ==========================================================================
// Timing
`define CPR_CLK_PERIOD_NS  4
`define CPR_TICK_NS        1000
`define CPR_TICK_CYC       (`CPR_TICK_NS / `CPR_CLK_PERIOD_NS)
`define CPR_TICK_LAST      8'hF9
`define CPR_TRIG_PULSE_US  16'h0005
// AXI responses
`define CPR_RESP_OKAY      2'h0
`define CPR_RESP_SLVERR    2'h2
`endif

// File: hw/cpr_us_pulse.v
// Microsecond delay pulse generator: high from rise to fall ticks after start
module cpr_us_pulse (
    input wire sys_clk_i,
    input wire arst_n_i,
    input wire tick_i,
    input wire start_i,
    input wire [15:0] rise_i,
    input wire [15:0] fall_i,
    output reg pulse_o
);
    reg [15:0] cnt_ff;
    reg run_ff;
    wire [15:0] nxt_cnt;

    assign nxt_cnt = cnt_ff + 16'h0001;

    // ======================================================================
    // Counter advanced by the 1 us tick; a new start restarts the pulse
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_ff <= 16'h0000;
            run_ff <= 1'b0;
            pulse_o <= 1'b0;
        end else if (start_i) begin
            cnt_ff <= 16'h0000;
            run_ff <= (fall_i != 16'h0000);
            pulse_o <= (rise_i == 16'h0000) && (fall_i != 16'h0000);
        end else if (run_ff && tick_i) begin
            cnt_ff <= nxt_cnt;
            pulse_o <= (nxt_cnt >= rise_i) && (nxt_cnt < fall_i);
            if (nxt_cnt >= fall_i) begin
                run_ff <= 1'b0;
            end
        end
    end
endmodule // cpr_us_pulse

// File: test/cpr_router_properties.sv
// Concurrent checks on the port router bus handshakes and event pins
module cpr_router_props (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic p0_oe_o,
    input wire logic [2:0] trig_event_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    // ==========================================================================
    // Bus handshakes
    a_rd_accept_gate: assert property (s_axi_arready_o == !s_axi_rvalid_o)
        else $error("arready not the inverse of rvalid");
    a_rd_answer_next: assert property (s_axi_arvalid_i && s_axi_arready_o
        |=> s_axi_rvalid_o) else $error("read answer late");
    a_rd_data_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read answer dropped or changed");
    a_wr_resp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write answer dropped or changed");
    a_wr_answer_bound: assert property (s_axi_awvalid_i && s_axi_awready_o
        && s_axi_wvalid_i && s_axi_wready_o |-> ##[1:3] s_axi_bvalid_o)
        else $error("write answer missing");
    a_wr_block_addr: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
        else $error("write address taken during response");
    // ==========================================================================
    // Events and port 0
    a_event_single_cycle: assert property (
        (trig_event_o & $past(trig_event_o)) == 3'h0)
        else $error("event held two cycles");
    a_p0_dir_by_write: assert property ($rose(p0_oe_o) |->
        s_axi_bvalid_o && s_axi_bresp_o == 2'h0)
        else $error("port 0 turned without write");
endmodule // cpr_router_props

// File: test/cpr_light_model.sv
// Lighting unit model on the far side of the output ports
module cpr_light_model (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic lvl_i,
    input wire logic p0_o_i,
    input wire logic p0_oe_i,
    input wire logic strobe_i,
    output wire logic p0_line_o,
    output logic [7:0] flash_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_ff;
    // Port 0 wire: camera drives when enabled, else the unit drives
    assign p0_line_o = p0_oe_i ? p0_o_i : lvl_i;
    // Counts flashes fired by strobe rising edges
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            last_ff <= 1'b0;
            flash_cnt_o <= 8'h00;
        end else begin
            last_ff <= strobe_i;
            if (strobe_i && !last_ff) flash_cnt_o <= flash_cnt_o + 8'h01;
        end
    end
endmodule // cpr_light_model

// File: test/tb.sv
// Self-checking bench of the camera output port router
`include "cpr_regs.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [5:0] awaddr = 6'h00;
    logic [5:0] araddr = 6'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, lvl = 1'b0, enc = 1'b0;
    logic [31:0] wdata = 32'h0, rd, v;
    logic [1:0] in_sig = 2'h0, rs;
    logic [2:0] done = 3'h0;
    logic [15:0] extra = 16'h0;
    logic [12:0] cfg;
    wire awready, wready, bvalid, arready, rvalid, p0_line, p0_o, p0_oe, term;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [2:0] out_o, trig_ev;
    wire [7:0] flashes;
    logic [7:0] hits, fl0;
    int num_errors = 0, compares = 0, cyc = 0, seed = 5889, p;
    cpr_router dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .p0_i(p0_line), .p0_o(p0_o), .p0_oe_o(p0_oe),
        .p0_term_en_o(term), .in_i(in_sig), .out_o(out_o),
        .enc_tick_i(enc), .pll_tick_i(1'b0), .trig_done_i(done),
        .extra_sig_i(extra), .trig_event_o(trig_ev));
    cpr_light_model lamp (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
        .lvl_i(lvl), .p0_o_i(p0_o), .p0_oe_i(p0_oe), .strobe_i(out_o[2]),
        .p0_line_o(p0_line), .flash_cnt_o(flashes));
    // ==========================================================================
    // Clock, timeout and verdict
    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            test_done();
        end
    end
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Expected software or extra level after the reverse stage
    function automatic logic exp_lvl(logic [12:0] c, logic [15:0] x);
        return (c[12] ? x[c[11:8]] : c[5]) ^ c[4];
    endfunction
    // ==========================================================================
    // Register bus master
    task automatic axw(input logic [5:0] a, input logic [31:0] d,
                       input logic [1:0] er);
        bit ha, hw, hb;
        int n;
        hb = 0;
        n = 0;
        @(posedge sys_clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!hb && n < 100) begin
            @(negedge sys_clk_i);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid;
            rs = bresp;
            @(posedge sys_clk_i);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        `CHK("bresp", {hb, er}, {1'b1, rs})
    endtask
    task automatic axr(input logic [5:0] a, input logic [1:0] er);
        bit ha, hb;
        int n;
        hb = 0;
        n = 0;
        @(posedge sys_clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!hb && n < 100) begin
            @(negedge sys_clk_i);
            ha = arvalid && arready;
            hb = rvalid;
            rd = rdata;
            rs = rresp;
            @(posedge sys_clk_i);
            if (ha) arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        `CHK("rresp", {hb, er}, {1'b1, rs})
    endtask
    // ==========================================================================
    // Scenarios
    initial begin
        repeat (12) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        @(negedge sys_clk_i);
        `CHK("p0_oe", 1'b0, p0_oe)
        `CHK("term", 1'b0, term)
        axr(`CPR_OFS_STATUS, `CPR_RESP_OKAY);
        `CHK("status", 32'h0000_0007, rd)
        axr(`CPR_OFS_TRIG_SRC, `CPR_RESP_OKAY);
        `CHK("trig_src", 9'h1FF, {rd[10:8], rd[6:4], rd[2:0]})
        axr(6'h30, `CPR_RESP_SLVERR);
        `CHK("unmapped", 32'h0, rd)
        axw(6'h3C, 32'hFFFF_FFFF, `CPR_RESP_SLVERR);
        axw(`CPR_OFS_STATUS, 32'hFFFF_FFFF, `CPR_RESP_SLVERR);
        for (int i = 0; i < 12; i++) begin
            v = $random(seed);
            p = i % 3;
            cfg = v[12:0] & 13'h1F30;
            extra <= v[31:16];
            axw(6'(4 * (p + 1)), {19'h0, cfg}, `CPR_RESP_OKAY);
            repeat (2) @(negedge sys_clk_i);
            `CHK("out", exp_lvl(cfg, extra), out_o[p])
        end
        axw(`CPR_OFS_P0_CTRL, 32'h3, `CPR_RESP_OKAY);
        axw(`CPR_OFS_PORT0, 32'h20, `CPR_RESP_OKAY);
        repeat (2) @(negedge sys_clk_i);
        `CHK("p0 out", 3'h7, {p0_oe, p0_line, term})
        axw(`CPR_OFS_TRIG_SRC, 32'h0717, `CPR_RESP_OKAY);
        axw(`CPR_OFS_PORT1, 32'h4, `CPR_RESP_OKAY);
        axw(`CPR_OFS_PORT2, 32'h7, `CPR_RESP_OKAY);
        axw(`CPR_OFS_STB_RISE, 32'h1, `CPR_RESP_OKAY);
        axw(`CPR_OFS_STB_FALL, 32'h4, `CPR_RESP_OKAY);
        axw(`CPR_OFS_PORT3, 32'h2, `CPR_RESP_OKAY);
        @(posedge sys_clk_i);
        in_sig <= 2'b01;
        hits = 0;
        while (!trig_ev[1] && hits < 50) begin
            @(negedge sys_clk_i);
            hits++;
        end
        `CHK("event", 1'b1, trig_ev[1])
        fl0 = flashes;
        repeat (3) @(negedge sys_clk_i);
        `CHK("pulse hi", 2'b01, out_o[1:0])
        @(posedge sys_clk_i);
        in_sig <= 2'b00;
        repeat (5) @(posedge sys_clk_i);
        in_sig <= 2'b01;
        hits = 0;
        repeat (30) begin
            @(negedge sys_clk_i);
            hits += trig_ev[1];
        end
        `CHK("ignored", 8'h00, hits)
        repeat (360) @(negedge sys_clk_i);
        `CHK("strobe hi", 1'b1, out_o[2])
        repeat (500) @(negedge sys_clk_i);
        `CHK("pulse width", 1'b1, out_o[0])
        repeat (400) @(negedge sys_clk_i);
        `CHK("pulse end", 2'b00, {out_o[2], out_o[0]})
        `CHK("flashes", 8'h01, flashes - fl0)
        @(posedge sys_clk_i);
        done <= 3'b010;
        @(posedge sys_clk_i);
        done <= 3'b000;
        repeat (3) @(negedge sys_clk_i);
        `CHK("rearm", 1'b1, out_o[1])
        axw(`CPR_OFS_TRIG_SRC, 32'h0713, `CPR_RESP_OKAY);
        enc <= 1'b1;
        axr(`CPR_OFS_STATUS, `CPR_RESP_OKAY);
        `CHK("enc event", 3'h6, rd[2:0])
        test_done();
    end
endmodule // tb
bind cpr_router cpr_router_props u_props (.sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i), .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i), .p0_oe_o(p0_oe_o),
    .trig_event_o(trig_event_o));
